// *** common/bbx_pkg.sv ***
// bbx_pkg: constants shared by the branch and bit-op execute block.
// assumes one core clock with four quarter phases per instruction cycle.
package bbx_pkg;
	localparam int PC_W = 21;
	localparam int INSTR_W = 16;
	localparam int DATA_W = 8;
	localparam int BANK_W = 4;
	localparam int ADDR_W = 12;

	// quarter phases of one instruction cycle
	localparam logic [1:0] PH_Q1 = 2'h0;
	localparam logic [1:0] PH_Q2 = 2'h1;
	localparam logic [1:0] PH_Q3 = 2'h2;
	localparam logic [1:0] PH_Q4 = 2'h3;
	localparam logic [1:0] PH_RESET = 2'h0;

	// opcode fields
	localparam logic [7:0] OPC_BRANCH_IF_ZERO_CLEAR = 8'he1;
	localparam logic [4:0] OPC_RELATIVE_JUMP_ALWAYS = 5'h1a;
	localparam logic [3:0] OPC_SINGLE_BIT_SET = 4'h8;
	localparam logic [3:0] OPC_TEST_BIT_SKIP_IF_CLEAR = 4'hb;
	localparam logic [3:0] OPC_TEST_BIT_SKIP_IF_ONE = 4'ha;

	// field positions within the instruction word
	localparam int SHORT_OFS_W = 8;
	localparam int LONG_OFS_W = 11;
	localparam int BIT_IDX_LSB = 9;
	localparam int BIT_IDX_W = 3;
	localparam int ACCESS_BIT = 8;
	localparam int FILE_ADDR_W = 8;

	// fast-access bank: low half maps to bank 0, high half to the top bank
	localparam logic [7:0] ACCESS_SPLIT = 8'h80;
	localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
	localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;

	// idle cycles appended after a taken branch or a skip
	localparam logic [1:0] NOP_NONE = 2'h0;
	localparam logic [1:0] NOP_ONE = 2'h1;
	localparam logic [1:0] NOP_TWO = 2'h2;

	typedef enum logic [2:0] {
		BBX_OP_NONE = 3'b000,
		BBX_OP_BNZ = 3'b001,
		BBX_OP_JUMP = 3'b010,
		BBX_OP_SET = 3'b011,
		BBX_OP_SKIP_CLR = 3'b100,
		BBX_OP_SKIP_ONE = 3'b101
	} bbx_op_t;
endpackage : bbx_pkg

// *** dv/bbx_exec_props.sv ***
// checker for bbx_exec, watching its ports only
// assumes q_phase free-runs and strobes last one cycle
`timescale 1ns/1ps
`default_nettype none
module bbx_exec_props #(parameter int PC_W = 21)
(
	input wire logic clk, nrst, instr_valid, zero_flag, instr_take,
	input wire logic nop_cycle, pc_wr, reg_rd, reg_wr, discard_fetched,
	input wire logic [15:0] instr,
	input wire logic [1:0] q_phase,
	input wire logic [PC_W-1:0] program_counter, pc_target,
	input wire logic [3:0] bank_select_register,
	input wire logic [7:0] rd_data, reg_wdata,
	input wire logic [11:0] reg_addr
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	wire logic [2:0] bidx = instr[11:9];
	// access bank: upper half of the window lands in the top bank
	wire logic [11:0] ea = instr[8] ? {bank_select_register, instr[7:0]}
		: {{4{instr[7]}}, instr[7:0]};
	wire logic [PC_W-1:0] jd = PC_W'(signed'({instr[10:0], 1'b0}));
	wire logic [PC_W-1:0] bd = PC_W'(signed'({instr[7:0], 1'b0}));
	sequence s_bnz;
		instr_take && instr[15:8] == 8'he1;
	endsequence
	sequence s_jmp;
		instr_take && instr[15:11] == 5'h1a;
	endsequence
	a_take_gate: assert property (instr_take |-> q_phase == 2'h0
		&& instr_valid && !nop_cycle) else $error("take gate");
	a_bnz_taken: assert property (s_bnz ##2 !zero_flag |=> pc_wr
		&& pc_target == $past(program_counter) + $past(bd, 3)
		##1 nop_cycle [*4]) else $error("bnz taken");
	a_bnz_fall: assert property (s_bnz ##2 zero_flag |=>
		!pc_wr ##1 !nop_cycle) else $error("bnz fall");
	a_jump_pc: assert property (s_jmp |-> ##3 pc_wr
		&& pc_target == $past(program_counter) + $past(jd, 3))
		else $error("jump target");
	a_jump_idle: assert property (s_jmp |-> ##4 nop_cycle [*4]
		##1 !nop_cycle) else $error("jump idle");
	a_bit_addr: assert property (instr_take && (instr[15:12] == 4'h8
		|| instr[15:13] == 3'b101) |=> reg_rd && reg_addr == $past(ea))
		else $error("bit addr");
	a_set_write: assert property (instr_take && instr[15:12] == 4'h8
		|-> ##3 reg_wr && reg_wdata == ($past(rd_data)
		| (8'h01 << $past(bidx, 3)))) else $error("set write");
	a_skip_taken: assert property (instr_take && instr[15:13] == 3'b101
		##2 rd_data[$past(bidx, 2)] != $past(instr[12], 2)
		|=> discard_fetched ##1 nop_cycle) else $error("skip");
endmodule : bbx_exec_props
bind bbx_exec bbx_exec_props #(.PC_W(PC_W)) u_props (.clk, .nrst,
	.instr_valid, .zero_flag, .instr_take, .nop_cycle, .pc_wr, .reg_rd,
	.reg_wr, .discard_fetched, .instr, .q_phase, .program_counter,
	.pc_target, .bank_select_register, .rd_data, .reg_wdata, .reg_addr);
`default_nettype wire

// *** dv/bbx_file_model.sv ***
// banked data register file facing bbx_exec
// assumes read data is wanted one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module bbx_file_model
(
	input wire logic clk, reg_rd, reg_wr,
	input wire logic [11:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] rd_data
);
	logic [7:0] mem [4096];
	initial
	begin
		rd_data = 8'h5a;
		for (int a = 0; a < 4096; a++)
			mem[a] = 8'(a) ^ 8'((a >> 4) & 'hf0);
	end
	always @(posedge clk)
	begin
		if (reg_wr)
			mem[reg_addr] <= reg_wdata;
		// off the read slot the bus inverts each cycle, so a stale byte passes only every other cycle
		rd_data <= reg_rd ? mem[reg_addr] : ~rd_data;
	end
endmodule : bbx_file_model
`default_nettype wire

// *** dv/testbench.sv ***
// self-checking bench for bbx_exec against a behavioural register file
// assumes a free-running four-phase core clock
`timescale 1ns/1ps
`default_nettype none
module testbench;
	typedef struct {logic [15:0] i; logic z, n; logic [2:0] s;
		logic [20:0] v; int idle;} bbx_row_t;
	logic clk = 1'b0, nrst = 1'b0, instr_valid = 1'b0, zero_flag = 1'b0;
	logic next_is_two_word = 1'b0, instr_take, nop_cycle, pc_wr, reg_rd;
	logic reg_wr, discard_fetched;
	logic [15:0] instr = 16'h0000;
	logic [20:0] program_counter = 21'h001000, pc_target;
	logic [3:0] bank_select_register = 4'h3;
	logic [7:0] rd_data, reg_wdata;
	logic [11:0] reg_addr;
	logic [1:0] q_phase;
	int fails = 0, tests_run = 0, cyc = 0;
	bbx_row_t rows [14] = '{'{16'he1ff, 0, 0, 3'b100, 21'h000ffe, 1},
		'{16'he17f, 1, 0, 0, 0, 0}, '{16'he17f, 0, 0, 3'b100, 21'h0010fe, 1},
		'{16'hd3ff, 1, 0, 3'b100, 21'h0017fe, 1},
		'{16'hd400, 0, 0, 3'b100, 21'h000800, 1},
		'{16'h8e0a, 0, 0, 3'b010, 21'h8a, 0}, '{16'h89ff, 0, 0, 3'b010, 21'hdf, 0},
		'{16'h8090, 0, 0, 3'b010, 21'h61, 0}, '{16'hb020, 0, 0, 3'b001, 0, 1},
		'{16'hba20, 0, 0, 0, 0, 0}, '{16'haa20, 0, 0, 3'b001, 0, 1},
		'{16'ha020, 0, 0, 0, 0, 0}, '{16'hb020, 0, 1, 3'b001, 0, 2},
		'{16'hf000, 0, 0, 0, 0, 0}};
	bbx_exec #(.PC_W(21)) DUT (.clk, .nrst, .instr, .instr_valid, .zero_flag,
		.program_counter, .bank_select_register, .next_is_two_word, .rd_data,
		.instr_take, .nop_cycle, .q_phase, .pc_wr, .pc_target, .reg_rd,
		.reg_wr, .reg_addr, .reg_wdata, .discard_fetched);
	bbx_file_model u_file (.clk, .reg_rd, .reg_wr, .reg_addr, .reg_wdata,
		.rd_data);
	task automatic chk(input string n, input logic [31:0] e, g);
		tests_run++;
		if (g !== e)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_of_test
	task automatic run(input bbx_row_t r);
		int k = 0;
		int n = 0;
		@(negedge clk);
		{instr, zero_flag, next_is_two_word, instr_valid} = {r.i, r.z, r.n, 1'b1};
		#1;
		while (instr_take !== 1'b1 && k < 16)
		begin
			@(negedge clk);
			#1;
			k++;
		end
		chk("take", 1, instr_take);
		@(negedge clk);
		instr_valid = 1'b0;
		#1;
		chk("read", r.i[15:12] == 4'h8 || r.i[15:13] == 3'b101, reg_rd);
		repeat (2) @(negedge clk);
		#1;
		chk("strobes", r.s, {pc_wr, reg_wr, discard_fetched});
		if (r.s[2])
			chk("target", r.v, pc_target);
		if (r.s[1])
			chk("wdata", r.v, reg_wdata);
		repeat (12)
		begin
			@(negedge clk);
			#1;
			n += nop_cycle;
		end
		chk("idle", r.idle * 4, n);
	endtask : run
	initial
		forever #10 clk = ~clk;
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			fails++;
			end_of_test;
		end
	end
	initial
	begin
		repeat (20) @(negedge clk);
		nrst = 1'b1;
		foreach (rows[j])
			run(rows[j]);
		@(negedge clk);
		nrst = 1'b0;
		#1;
		chk("reset", 0, {pc_wr, reg_wr, reg_rd, discard_fetched, nop_cycle,
			q_phase});
		@(negedge clk);
		nrst = 1'b1;
		run(rows[0]);
		end_of_test;
	end
endmodule : testbench
`default_nettype wire

// *** hw/bbx_bank_addr.sv ***
// bbx_bank_addr: forms the full data address of a register operand.
// assumes the bank select register value is stable while it is used.
`timescale 1ns/1ps
`default_nettype none
module bbx_bank_addr
(
	input wire logic access_sel,
	input wire logic [bbx_pkg::BANK_W-1:0] bank_select_register,
	input wire logic [bbx_pkg::FILE_ADDR_W-1:0] file_addr,
	output logic [bbx_pkg::ADDR_W-1:0] full_addr
);
	logic [bbx_pkg::BANK_W-1:0] bank;

	always_comb
	begin
		if (access_sel)
			bank = bank_select_register;
		else if (file_addr < bbx_pkg::ACCESS_SPLIT)
			bank = bbx_pkg::ACCESS_LOW_BANK;
		else
			bank = bbx_pkg::ACCESS_HIGH_BANK;
		full_addr = {bank, file_addr};
	end
endmodule : bbx_bank_addr
`default_nettype wire

// *** hw/bbx_exec.sv ***
// bbx_exec: decode and execute of conditional/unconditional relative
// branches, single-bit set and the bit-test skips of an 8-bit core.
// assumes the fetch pipeline offers the next word at Q1, the program
// counter input already points past the current word, and the register
// file returns read data in the cycle after a read strobe.
`timescale 1ns/1ps
`default_nettype none
module bbx_exec
#(
	parameter int PC_W = bbx_pkg::PC_W
)
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic [bbx_pkg::INSTR_W-1:0] instr,
	input wire logic instr_valid,
	input wire logic zero_flag,
	input wire logic [PC_W-1:0] program_counter,
	input wire logic [bbx_pkg::BANK_W-1:0] bank_select_register,
	input wire logic next_is_two_word,
	input wire logic [bbx_pkg::DATA_W-1:0] rd_data,
	output logic instr_take,
	output logic nop_cycle,
	output logic [1:0] q_phase,
	output logic pc_wr,
	output logic [PC_W-1:0] pc_target,
	output logic reg_rd,
	output logic reg_wr,
	output logic [bbx_pkg::ADDR_W-1:0] reg_addr,
	output logic [bbx_pkg::DATA_W-1:0] reg_wdata,
	output logic discard_fetched
);
	bbx_pkg::bbx_op_t op, next_op;
	logic [1:0] next_q_phase;
	logic [1:0] nop_left, next_nop_left;
	logic idle, next_idle;
	logic [bbx_pkg::INSTR_W-1:0] held, next_held;
	logic next_pc_wr;
	logic [PC_W-1:0] next_pc_target;
	logic next_reg_rd;
	logic next_reg_wr;
	logic [bbx_pkg::ADDR_W-1:0] next_reg_addr;
	logic [bbx_pkg::DATA_W-1:0] next_reg_wdata;
	logic next_discard;
	logic [bbx_pkg::ADDR_W-1:0] operand_addr;
	logic [PC_W-1:0] short_disp;
	logic [PC_W-1:0] long_disp;
	logic [bbx_pkg::DATA_W-1:0] bit_mask;
	logic tested_bit;

	// operand address of the word being decoded at Q1
	bbx_bank_addr u_bank_addr
	(
		.access_sel(instr[bbx_pkg::ACCESS_BIT]),
		.bank_select_register(bank_select_register),
		.file_addr(instr[bbx_pkg::FILE_ADDR_W-1:0]),
		.full_addr(operand_addr)
	);

	// offsets sign-extended and doubled; the counter is already past
	// the word, which yields current address plus 2 plus 2n
	assign short_disp = PC_W'({{(PC_W-bbx_pkg::SHORT_OFS_W){
		held[bbx_pkg::SHORT_OFS_W-1]}},
		held[bbx_pkg::SHORT_OFS_W-1:0]} << 1);
	assign long_disp = PC_W'({{(PC_W-bbx_pkg::LONG_OFS_W){
		held[bbx_pkg::LONG_OFS_W-1]}},
		held[bbx_pkg::LONG_OFS_W-1:0]} << 1);

	// three-bit index covers 0..7 and eight-bit address 0..255 fully
	assign bit_mask = bbx_pkg::DATA_W'(8'h01 <<
		held[bbx_pkg::BIT_IDX_LSB +: bbx_pkg::BIT_IDX_W]);
	assign tested_bit = |(rd_data & bit_mask);

	// a new word is taken only at Q1 and never during idle cycles
	assign instr_take = (q_phase == bbx_pkg::PH_Q1) && !idle
		&& instr_valid;
	assign nop_cycle = idle;

	always_comb
	begin
		next_q_phase = q_phase + 2'h1;
		next_op = op;
		next_held = held;
		next_nop_left = nop_left;
		next_idle = idle;
		next_pc_wr = 1'b0;
		next_pc_target = pc_target;
		next_reg_rd = 1'b0;
		next_reg_wr = 1'b0;
		next_reg_addr = reg_addr;
		next_reg_wdata = reg_wdata;
		next_discard = 1'b0;
		case (q_phase)
			bbx_pkg::PH_Q1:
			begin
				next_op = bbx_pkg::BBX_OP_NONE;
				if (!idle && instr_valid)
				begin
					next_held = instr;
					if (instr[15:8] == bbx_pkg::OPC_BRANCH_IF_ZERO_CLEAR)
						next_op = bbx_pkg::BBX_OP_BNZ;
					else if (instr[15:11] == bbx_pkg::OPC_RELATIVE_JUMP_ALWAYS)
						next_op = bbx_pkg::BBX_OP_JUMP;
					else if (instr[15:12] == bbx_pkg::OPC_SINGLE_BIT_SET)
						next_op = bbx_pkg::BBX_OP_SET;
					else if (instr[15:12] == bbx_pkg::OPC_TEST_BIT_SKIP_IF_CLEAR)
						next_op = bbx_pkg::BBX_OP_SKIP_CLR;
					else if (instr[15:12] == bbx_pkg::OPC_TEST_BIT_SKIP_IF_ONE)
						next_op = bbx_pkg::BBX_OP_SKIP_ONE;
					else
						next_op = bbx_pkg::BBX_OP_NONE;
					// bit ops read their register during Q2
					if (next_op == bbx_pkg::BBX_OP_SET ||
						next_op == bbx_pkg::BBX_OP_SKIP_CLR ||
						next_op == bbx_pkg::BBX_OP_SKIP_ONE)
					begin
						next_reg_rd = 1'b1;
						next_reg_addr = operand_addr;
					end
				end
			end
			bbx_pkg::PH_Q2:
			begin
				// read data arrives during Q3; nothing to launch here
				next_op = op;
			end
			bbx_pkg::PH_Q3:
			begin
				// decisions made here take effect in Q4
				case (op)
					bbx_pkg::BBX_OP_BNZ:
						if (!zero_flag)
						begin
							next_pc_wr = 1'b1;
							next_pc_target = program_counter + short_disp;
							next_nop_left = bbx_pkg::NOP_ONE;
						end
					bbx_pkg::BBX_OP_JUMP:
					begin
						next_pc_wr = 1'b1;
						next_pc_target = program_counter + long_disp;
						next_nop_left = bbx_pkg::NOP_ONE;
					end
					bbx_pkg::BBX_OP_SET:
					begin
						next_reg_wr = 1'b1;
						next_reg_wdata = rd_data | bit_mask;
					end
					bbx_pkg::BBX_OP_SKIP_CLR,
					bbx_pkg::BBX_OP_SKIP_ONE:
						if (tested_bit == (op == bbx_pkg::BBX_OP_SKIP_ONE))
						begin
							next_discard = 1'b1;
							next_nop_left = next_is_two_word ?
								bbx_pkg::NOP_TWO : bbx_pkg::NOP_ONE;
						end
					default:
						next_op = bbx_pkg::BBX_OP_NONE;
				endcase
			end
			bbx_pkg::PH_Q4:
			begin
				// flags are never driven: none of these ops alter status
				next_op = bbx_pkg::BBX_OP_NONE;
				// idle spans whole instruction cycles, so fetch sees
				// nop_cycle through all four phases of each one
				next_idle = (nop_left != 2'h0);
				if (nop_left != 2'h0)
					next_nop_left = nop_left - 2'h1;
			end
			default:
				next_q_phase = bbx_pkg::PH_RESET;
		endcase
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			q_phase <= bbx_pkg::PH_RESET;
			op <= bbx_pkg::BBX_OP_NONE;
			held <= '0;
			nop_left <= bbx_pkg::NOP_NONE;
			idle <= 1'b0;
			pc_wr <= 1'b0;
			pc_target <= '0;
			reg_rd <= 1'b0;
			reg_wr <= 1'b0;
			reg_addr <= '0;
			reg_wdata <= '0;
			discard_fetched <= 1'b0;
		end
		else
		begin
			q_phase <= next_q_phase;
			op <= next_op;
			held <= next_held;
			nop_left <= next_nop_left;
			idle <= next_idle;
			pc_wr <= next_pc_wr;
			pc_target <= next_pc_target;
			reg_rd <= next_reg_rd;
			reg_wr <= next_reg_wr;
			reg_addr <= next_reg_addr;
			reg_wdata <= next_reg_wdata;
			discard_fetched <= next_discard;
		end
	end
endmodule : bbx_exec
`default_nettype wire
